// [logic/spio_port.sv]
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - muxes choose peripheral or port output
// - port output never loops into peripheral
// - active output-capable peripheral disables port driver
// - idle enabled peripheral lets port drive
// - direction one input, zero output
// - reset makes every pin input
// - latch reads latch, writes latch
// - pin reads levels, writes latch
// - unimplemented bits disabled, read zero except in analog select registers
// - input-only sharing means dedicated port
// - open-drain drives low only on port output; a peripheral-owned pin drives both levels
// - cleared analog bit selects analog mode
// - analog pins reset to analog
// - either converter clearing selects analog
// - analog pins read zero
// - digital input pins never convert
// - shutoff converter no longer selects analog
module spio_port
	import spio_pkg::*;
#(
	parameter int              WIDTH         = SPIO_WIDTH,
	parameter logic [15:0]     IMPL_MASK     = 16'hFFFF,
	parameter logic [15:0]     ANALOG_MASK   = 16'h00FF,
	parameter logic [15:0]     ODC_MASK      = 16'hFFFF,
	parameter logic [15:0]     PERIPH_OUT_MASK = 16'hFF00
)(
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic [SPIO_AW-1:0] addr,
	input  wire logic [15:0]        wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	output logic      [15:0]        rdata,
	input  wire logic [WIDTH-1:0]   pin_in,
	output logic      [WIDTH-1:0]   pin_out,
	output logic      [WIDTH-1:0]   pin_oe_n,
	input  wire logic [WIDTH-1:0]   periph_en,
	input  wire logic [WIDTH-1:0]   periph_drive,
	input  wire logic [WIDTH-1:0]   periph_out,
	output logic      [WIDTH-1:0]   periph_in,
	output logic      [WIDTH-1:0]   analog_mode,
	output logic      [WIDTH-1:0]   convert_enable
);

	logic [WIDTH-1:0] pin_direction_bits_r;
	logic [WIDTH-1:0] output_latch_bits_r;
	logic [WIDTH-1:0] open_drain_select_bits_r;
	logic [WIDTH-1:0] first_converter_analog_select_r;
	logic [WIDTH-1:0] second_converter_analog_select_r;
	logic [1:0]       second_converter_shutoff_r;
	logic [15:0]      rdata_r;
	logic [WIDTH-1:0] pin_out_r;
	logic [WIDTH-1:0] pin_oe_n_r;
	logic [WIDTH-1:0] periph_in_r;
	logic [WIDTH-1:0] analog_mode_r;
	logic [WIDTH-1:0] convert_r;

	wire logic [WIDTH-1:0] impl_w;
	wire logic [WIDTH-1:0] sampled_w;
	wire logic [WIDTH-1:0] ana1_w;
	wire logic [WIDTH-1:0] ana2_w;
	wire logic [WIDTH-1:0] ana_mode_w;
	wire logic [WIDTH-1:0] pin_level_bits_w;
	wire logic [WIDTH-1:0] mux_out_w;
	wire logic [WIDTH-1:0] mux_oe_n_w;
	wire logic [WIDTH-1:0] mux_pin_w;
	wire logic [WIDTH-1:0] periph_in_w;
	wire logic             wr_dir;
	wire logic             wr_latch;
	wire logic             wr_odc;
	wire logic             wr_ana1;
	wire logic             wr_ana2;
	wire logic             wr_shut;
	wire logic [WIDTH-1:0] wd;
	logic      [15:0]      rd_sel;

	assign impl_w = IMPL_MASK[WIDTH-1:0];
	assign wd     = wdata[WIDTH-1:0];

	assign wr_dir   = wr & (addr == SPIO_OFF_DIR);
	assign wr_latch = wr & ((addr == SPIO_OFF_LATCH) | (addr == SPIO_OFF_PIN));
	assign wr_odc   = wr & (addr == SPIO_OFF_ODC);
	assign wr_ana1  = wr & (addr == SPIO_OFF_ANA1);
	assign wr_ana2  = wr & (addr == SPIO_OFF_ANA2);
	assign wr_shut  = wr & (addr == SPIO_OFF_SHUTOFF);

	// analog when a live converter holds the bit cleared
	assign ana1_w = second_converter_shutoff_r[SPIO_SHUT_FIRST]
		? '0 : ~first_converter_analog_select_r;
	assign ana2_w = second_converter_shutoff_r[SPIO_SHUT_SECOND]
		? '0 : ~second_converter_analog_select_r;
	assign ana_mode_w = (ana1_w | ana2_w) & ANALOG_MASK[WIDTH-1:0] & impl_w;

	spio_sample #(
		.WIDTH (WIDTH)
	) u_sample (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       (mux_pin_w),
		.q       (sampled_w)
	);

	assign pin_level_bits_w = sampled_w & ~ana_mode_w & impl_w;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_pin
			spio_pin_mux u_mux (
				.impl               (impl_w[g]),
				.dir_in             (pin_direction_bits_r[g]),
				.latch              (output_latch_bits_r[g]),
				.odc                (open_drain_select_bits_r[g]),
				.odc_ok             (ODC_MASK[g]),
				.periph_out_capable (PERIPH_OUT_MASK[g]),
				.periph_en          (periph_en[g]),
				.periph_drive       (periph_drive[g]),
				.periph_out         (periph_out[g]),
				.pin_level          (pin_in[g]),
				.pad_out            (mux_out_w[g]),
				.pad_oe_n           (mux_oe_n_w[g]),
				.periph_in          (periph_in_w[g])
			);
			assign mux_pin_w[g] = pin_in[g];
		end
	endgenerate

	always_comb
	begin
		rd_sel = 16'h0000;
		unique case (addr)
			SPIO_OFF_DIR:     rd_sel[WIDTH-1:0] = pin_direction_bits_r & impl_w;
			SPIO_OFF_LATCH:   rd_sel[WIDTH-1:0] = output_latch_bits_r & impl_w;
			SPIO_OFF_PIN:     rd_sel[WIDTH-1:0] = pin_level_bits_w;
			SPIO_OFF_ODC:     rd_sel[WIDTH-1:0] = open_drain_select_bits_r & ODC_MASK[WIDTH-1:0] & impl_w;
			SPIO_OFF_ANA1:    rd_sel[WIDTH-1:0] = first_converter_analog_select_r;
			SPIO_OFF_ANA2:    rd_sel[WIDTH-1:0] = second_converter_analog_select_r;
			SPIO_OFF_SHUTOFF: rd_sel[1:0]       = second_converter_shutoff_r;
			SPIO_OFF_ANAMODE: rd_sel[WIDTH-1:0] = ana_mode_w;
			default:          rd_sel            = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pin_direction_bits_r             <= SPIO_RST_DIR[WIDTH-1:0];
			output_latch_bits_r              <= SPIO_RST_LATCH[WIDTH-1:0];
			open_drain_select_bits_r         <= SPIO_RST_ODC[WIDTH-1:0];
			first_converter_analog_select_r  <= SPIO_RST_ANA[WIDTH-1:0];
			second_converter_analog_select_r <= SPIO_RST_ANA[WIDTH-1:0];
			second_converter_shutoff_r       <= SPIO_RST_SHUTOFF;
		end
		else
		begin
			if (wr_dir)
				pin_direction_bits_r <= wd & impl_w;
			if (wr_latch)
				output_latch_bits_r <= wd & impl_w;
			if (wr_odc)
				open_drain_select_bits_r <= wd & impl_w;
			if (wr_ana1)
				first_converter_analog_select_r <= wd;
			if (wr_ana2)
				second_converter_analog_select_r <= wd;
			if (wr_shut)
				second_converter_shutoff_r <= wdata[1:0];
		end
	end

	// outputs registered
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rdata_r       <= 16'h0000;
			pin_out_r     <= '0;
			pin_oe_n_r    <= '1;
			// select registers come out of reset cleared, so analog pins are analog at once
			analog_mode_r <= ANALOG_MASK[WIDTH-1:0] & IMPL_MASK[WIDTH-1:0];
			convert_r     <= ANALOG_MASK[WIDTH-1:0] & IMPL_MASK[WIDTH-1:0];
		end
		else
		begin
			rdata_r       <= rd ? rd_sel : 16'h0000;
			pin_out_r     <= mux_out_w;
			pin_oe_n_r    <= mux_oe_n_w;
			analog_mode_r <= ana_mode_w;
			convert_r     <= ana_mode_w;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			periph_in_r <= '0;
		else
			periph_in_r <= periph_in_w;
	end

	assign rdata          = rdata_r;
	assign pin_out        = pin_out_r;
	assign pin_oe_n       = pin_oe_n_r;
	assign periph_in      = periph_in_r;
	assign analog_mode    = analog_mode_r;
	assign convert_enable = convert_r;

endmodule : spio_port

// [logic/spio_pkg.sv]
package spio_pkg;

	localparam int SPIO_WIDTH = 16;
	localparam int SPIO_AW    = 4;

	// register offsets
	localparam logic [3:0] SPIO_OFF_DIR      = 4'h0;
	localparam logic [3:0] SPIO_OFF_LATCH    = 4'h1;
	localparam logic [3:0] SPIO_OFF_PIN      = 4'h2;
	localparam logic [3:0] SPIO_OFF_ODC      = 4'h3;
	localparam logic [3:0] SPIO_OFF_ANA1     = 4'h4;
	localparam logic [3:0] SPIO_OFF_ANA2     = 4'h5;
	localparam logic [3:0] SPIO_OFF_SHUTOFF  = 4'h6;
	localparam logic [3:0] SPIO_OFF_ANAMODE  = 4'h7;

	// reset values
	localparam logic [15:0] SPIO_RST_DIR     = 16'hFFFF;
	localparam logic [15:0] SPIO_RST_LATCH   = 16'h0000;
	localparam logic [15:0] SPIO_RST_ODC     = 16'h0000;
	localparam logic [15:0] SPIO_RST_ANA     = 16'h0000;
	localparam logic [1:0]  SPIO_RST_SHUTOFF = 2'h0;

	// shutoff register field positions
	localparam int SPIO_SHUT_FIRST  = 0;
	localparam int SPIO_SHUT_SECOND = 1;

endpackage : spio_pkg

// [logic/spio_sample.sv]
`timescale 1ns/1ps
module spio_sample
	import spio_pkg::*;
#(
	parameter int WIDTH = 16
)(
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

endmodule : spio_sample

// [logic/spio_pin_mux.sv]
`timescale 1ns/1ps
module spio_pin_mux
	import spio_pkg::*;
(
	input  wire logic impl,
	input  wire logic dir_in,
	input  wire logic latch,
	input  wire logic odc,
	input  wire logic odc_ok,
	input  wire logic periph_out_capable,
	input  wire logic periph_en,
	input  wire logic periph_drive,
	input  wire logic periph_out,
	input  wire logic pin_level,
	output logic      pad_out,
	output logic      pad_oe_n,
	output logic      periph_in
);

	wire logic per_owns;
	wire logic port_drive;
	wire logic od_mode;

	assign per_owns   = impl & periph_out_capable & periph_en & periph_drive;
	assign port_drive = impl & ~per_owns & ~dir_in;
	assign od_mode    = odc & odc_ok;

	always_comb
	begin
		if (per_owns)
		begin
			pad_out  = periph_out;
			pad_oe_n = 1'b0;
		end
		else if (port_drive)
		begin
			pad_out  = od_mode ? 1'b0 : latch;
			pad_oe_n = od_mode & latch;
		end
		else
		begin
			pad_out  = 1'b0;
			pad_oe_n = 1'b1;
		end
	end

	// port's own drive never loops into the peripheral input
	assign periph_in = (port_drive | ~impl) ? 1'b0 : pin_level;

endmodule : spio_pin_mux

// [sim/spio_port_chk.sv]
`timescale 1ns/1ps
module spio_port_chk
	import spio_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [3:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe_n,
	input wire logic [15:0] periph_en,
	input wire logic [15:0] periph_drive,
	input wire logic [15:0] periph_out,
	input wire logic [15:0] periph_in,
	input wire logic [15:0] analog_mode,
	input wire logic [15:0] convert_enable
);
	logic        rst_q;
	logic [15:0] own;
	assign own = periph_en & periph_drive & 16'hFF00;
	always_ff @(posedge ref_clk) rst_q <= rst;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_lat;
		(wr && (addr == SPIO_OFF_LATCH || addr == SPIO_OFF_PIN)) ##1 !wr ##1 (rd && addr == SPIO_OFF_LATCH)
		|=> rdata == $past(wdata, 3);
	endproperty
	a_lat: assert property (p_lat) else $error("latch readback wrong");
	property p_unmap; $past(rd && addr > SPIO_OFF_ANAMODE) |-> rdata == 16'h0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_own; !rst_q |-> (((pin_out ^ $past(periph_out)) | pin_oe_n) & $past(own)) == 16'h0000; endproperty
	a_own: assert property (p_own) else $error("peripheral lost its pin");
	property p_rst; rst_q |-> pin_oe_n == 16'hFFFF && analog_mode == 16'h00FF; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_pin; $past(rd && addr == SPIO_OFF_PIN) && $stable(analog_mode) |-> (rdata & analog_mode) == 16'h0000; endproperty
	a_pin: assert property (p_pin) else $error("analog pin read not zero");
	property p_mode; $past(rd && addr == SPIO_OFF_ANAMODE) && $stable(analog_mode) |-> rdata == analog_mode; endproperty
	a_mode: assert property (p_mode) else $error("mode status differs");
	property p_cvt; convert_enable == analog_mode; endproperty
	a_cvt: assert property (p_cvt) else $error("convert on digital pin");
	property p_loop; !rst_q |-> (periph_in & ~pin_oe_n & ~$past(own)) == 16'h0000; endproperty
	a_loop: assert property (p_loop) else $error("port output loops to peripheral");
endmodule : spio_port_chk
bind spio_port spio_port_chk spio_port_chk_i (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_en(periph_en), .periph_drive(periph_drive),
	.periph_out(periph_out), .periph_in(periph_in), .analog_mode(analog_mode), .convert_enable(convert_enable));

// [sim/spio_board.sv]
`timescale 1ns/1ps
module spio_board
(
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe_n,
	input  wire logic [15:0] ext,
	output logic      [15:0] pin_in
);
	// driven bits follow the port, released bits follow the board
	assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule : spio_board

// [sim/spio_port_bench.sv]
`timescale 1ns/1ps
module spio_port_bench
	import spio_pkg::*;
;
	logic        ref_clk, rst, wr, rd;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, pin_in, pin_out, pin_oe_n, p_en, p_drv, p_out, p_in, a_mode, cvt, ext;
	int          fails, samples_checked;
	spio_port spio_port_i (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_en(p_en), .periph_drive(p_drv),
		.periph_out(p_out), .periph_in(p_in), .analog_mode(a_mode), .convert_enable(cvt));
	spio_board spio_board_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .pin_in(pin_in));
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
		// one idle cycle before any read-back
		@(posedge ref_clk);
	endtask : wreg
	task automatic rreg(input logic [3:0] a, input logic [15:0] e, input string n);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(negedge ref_clk);
		chk(n, rdata, e);
		@(posedge ref_clk);
	endtask : rreg
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial
	begin
		#200000;
		fails++;
		wrap_up();
	end
	initial
	begin
		{rst, wr, rd, addr, wdata, p_en, p_drv, p_out, fails, samples_checked} = '0;
		rst = 1'b1;
		ext = 16'hA5C3;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk("oe_n", pin_oe_n, 16'hFFFF);
		chk("analog_mode", a_mode, 16'h00FF);
		@(posedge ref_clk);
		rreg(SPIO_OFF_DIR, 16'hFFFF, "dir");
		rreg(SPIO_OFF_ANAMODE, 16'h00FF, "mode");
		rreg(SPIO_OFF_PIN, 16'hA500, "pin");
		rreg(4'h9, 16'h0000, "unmapped");
		wreg(SPIO_OFF_ANA1, 16'hFFFF);
		wreg(SPIO_OFF_ANA2, 16'hFF0F);
		rreg(SPIO_OFF_ANAMODE, 16'h00F0, "mode");
		chk("convert", cvt, 16'h00F0);
		chk("analog_mode", a_mode, 16'h00F0);
		rreg(SPIO_OFF_PIN, 16'hA503, "pin");
		wreg(SPIO_OFF_SHUTOFF, 16'h0002);
		rreg(SPIO_OFF_ANAMODE, 16'h0000, "mode");
		wreg(SPIO_OFF_ANA1, 16'h0000);
		wreg(SPIO_OFF_SHUTOFF, 16'h0003);
		rreg(SPIO_OFF_SHUTOFF, 16'h0003, "shutoff");
		rreg(SPIO_OFF_ANAMODE, 16'h0000, "mode");
		rreg(SPIO_OFF_PIN, 16'hA5C3, "pin");
		wreg(SPIO_OFF_PIN, 16'h1234);
		rreg(SPIO_OFF_LATCH, 16'h1234, "latch");
		wreg(SPIO_OFF_LATCH, 16'h5678);
		rreg(SPIO_OFF_LATCH, 16'h5678, "latch");
		wreg(SPIO_OFF_ODC, 16'h00FF);
		rreg(SPIO_OFF_ODC, 16'h00FF, "odc");
		// clearing direction drives every pin; open-drain low byte releases pins whose latch is high
		wreg(SPIO_OFF_DIR, 16'h0000);
		@(negedge ref_clk);
		chk("oe_n", pin_oe_n, 16'h0078);
		chk("pin_out", pin_out, 16'h5600);
		@(posedge ref_clk);
		wreg(SPIO_OFF_ODC, 16'h0000);
		p_en <= 16'hFFFF;
		p_drv <= 16'h0F0F;
		p_out <= 16'h0AFF;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("pin_out", pin_out, 16'h5A78);
		chk("oe_n", pin_oe_n, 16'h0000);
		chk("to_periph", p_in & 16'hF0FF, 16'h0000);
		chk("from_pin", p_in & 16'h0F00, 16'h0A00);
		@(posedge ref_clk);
		rreg(SPIO_OFF_PIN, 16'h5A78, "pin");
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rreg(SPIO_OFF_DIR, 16'hFFFF, "dir");
		rreg(SPIO_OFF_ANAMODE, 16'h00FF, "mode");
		wrap_up();
	end
endmodule : spio_port_bench
